// *** src/hpm_pkg.sv ***
// Shared constants, device map and types for the two-wire host controller
package hpm_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam int FILT_NS = 50;
  localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);
  localparam int BUS_FREE_NS = 4700;
  localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] BUS_FREE_QTRS = 2'((BUS_FREE_CYC + QTR_CYC - 1) / QTR_CYC);

  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [2:0] ROW_BYTES = 3'h4;

  // Device map, lower memory
  localparam logic [7:0] REG_COND_CTRL = 8'h01;
  localparam int COND_CTRL_A_BIT = 2;
  localparam int COND_CTRL_B_BIT = 1;
  localparam logic [7:0] REG_HOST_PASSWORD_SETTING = 8'h77;
  localparam logic [7:0] REG_PASSWORD_ENTRY = 8'h7b;
  localparam logic [7:0] REG_TABLE_SELECT = 8'h7f;
  // Device map, upper tables
  localparam logic [7:0] REG_EXT_SENSOR_A_SCALE_PRESET = 8'h80;
  localparam logic [7:0] REG_EXT_SENSOR_B_SCALE_PRESET = 8'h82;
  localparam logic [7:0] REG_THRESHOLD_VOLTAGE_VALUE = 8'h87;
  localparam logic [7:0] REG_BIAS_MONITOR_OFFSET = 8'ha4;
  localparam logic [7:0] REG_TX_POWER_MONITOR_OFFSET = 8'ha6;
  localparam logic [7:0] REG_RX_POWER_MONITOR_OFFSET = 8'ha8;
  localparam logic [7:0] REG_AUX_ONE_MONITOR_OFFSET = 8'haa;
  localparam logic [7:0] REG_AUX_TWO_MONITOR_OFFSET = 8'hac;
  localparam logic [7:0] REG_TABLE_INDEX_POINTER = 8'hb0;
  localparam logic [7:0] REG_TABLE_CONFIG = 8'hb2;
  localparam logic [7:0] REG_QUICK_TRIP_STATUS = 8'hb4;
  localparam logic [7:0] REG_MODULE_PASSWORD_SETTING = 8'hb8;
  localparam logic [7:0] THRESHOLD_VOLTAGE_RST = 8'h80;
  localparam logic [15:0] MONITOR_OFFSET_RST = 16'h0000;
  localparam logic [7:0] TABLE_CONFIG_RST = 8'h03;
  localparam logic [31:0] MODULE_PASSWORD_RST = 32'hfffffff;
  localparam int CFG_TABLE_VALUE_OVERRIDE_BIT = 0;
  localparam int CFG_TABLE_FETCH_ENABLE_BIT = 1;
  localparam int CFG_SHADOW_NV_WRITE_BLOCK_BIT = 2;
  localparam int STAT_BIAS_HIGH_BIT = 2;
  localparam int STAT_TX_POWER_HIGH_BIT = 3;
  localparam int STAT_TX_POWER_LOW_BIT = 4;
  localparam int STAT_SHUTDOWN_BIT = 6;
  localparam int STAT_SAFETY_FAULT_BIT = 7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_XFER = 5'h04,
    ST_STOP = 5'h08,
    ST_DONE = 5'h10
  } hpm_st_t;

  typedef enum logic [4:0] {
    SG_ADDRW = 5'h01,
    SG_MEMA = 5'h02,
    SG_WDATA = 5'h04,
    SG_ADDRR = 5'h08,
    SG_RDATA = 5'h10
  } hpm_seg_t;

  typedef struct packed {
    logic rd;
    logic set_addr;
    logic [7:0] mem_addr;
    logic [2:0] len;
    logic [31:0] wdata;
  } hpm_cmd_t;

  typedef struct packed {
    logic nack;
    logic [31:0] rdata;
  } hpm_rsp_t;

  typedef struct packed {
    hpm_st_t st;
    hpm_seg_t seg;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [1:0] byte_cnt;
    logic [7:0] shreg;
    logic ack;
    hpm_cmd_t cmd;
    hpm_rsp_t rsp;
    logic sda_low;
    logic scl_low;
    logic sel_n;
  } hpm_state_t;

  localparam hpm_state_t STATE_RST = '{
    st: ST_IDLE, seg: SG_ADDRW, qtr: 2'h0, bitn: 4'h0, byte_cnt: 2'h0,
    shreg: 8'h00, ack: 1'b1, cmd: '0, rsp: '0, sda_low: 1'b0,
    scl_low: 1'b0, sel_n: 1'b1
  };

  typedef struct packed {
    logic meta;
    logic sync;
    logic [3:0] cnt;
    logic q;
  } hpm_filt_t;

  localparam hpm_filt_t FILT_RST = '{meta: 1'b1, sync: 1'b1, cnt: 4'h0, q: 1'b1};

  typedef struct packed {
    logic [7:0] cnt;
  } hpm_tick_t;

  localparam hpm_tick_t TICK_RST = '{cnt: 8'h00};

endpackage

// *** src/hpm_sync.sv ***
// Two-flop synchroniser with a stability filter for the bus pins
`timescale 1ns/10ps
module hpm_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] d_level,
  output logic [W-1:0] q_level
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      hpm_pkg::hpm_filt_t f_r;
      hpm_pkg::hpm_filt_t f_nxt;

      always_comb begin
        f_nxt = f_r;
        f_nxt.meta = d_level[gi];
        f_nxt.sync = f_r.meta;
        // A new level is taken only after it held for the whole filter time
        if (f_r.sync != f_r.q) begin
          if (f_r.cnt == hpm_pkg::FILT_LAST) begin
            f_nxt.q = f_r.sync;
            f_nxt.cnt = 4'h0;
          end else begin
            f_nxt.cnt = f_r.cnt + 4'h1;
          end
        end else begin
          f_nxt.cnt = 4'h0;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          f_r <= hpm_pkg::FILT_RST;
        end else begin
          f_r <= f_nxt;
        end
      end

      assign q_level[gi] = f_r.q;
    end
  endgenerate

endmodule

// *** src/hpm_qtr_tick.sv ***
// Quarter-period tick divider that paces the bus clock
`timescale 1ns/10ps
module hpm_qtr_tick (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run,
  output logic tick
);

  hpm_pkg::hpm_tick_t t_r;
  hpm_pkg::hpm_tick_t t_nxt;

  always_comb begin
    t_nxt = t_r;
    if (!run || t_r.cnt == hpm_pkg::QTR_LAST) begin
      t_nxt.cnt = 8'h00;
    end else begin
      t_nxt.cnt = t_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      t_r <= hpm_pkg::TICK_RST;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign tick = run && (t_r.cnt == hpm_pkg::QTR_LAST);

endmodule

// *** src/hpm_master.sv ***
// Two-wire bus host that reads and writes the laser-control device
`timescale 1ns/10ps
module hpm_master (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire hpm_pkg::hpm_cmd_t cmd,
  output logic rsp_valid,
  output hpm_pkg::hpm_rsp_t rsp,
  output logic bus_select_n,
  input wire logic scl_level,
  output logic scl_value,
  output logic scl_enable,
  input wire logic sda_level,
  output logic sda_value,
  output logic sda_enable
);

  hpm_pkg::hpm_state_t s_r;
  hpm_pkg::hpm_state_t s_nxt;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic adv;
  logic wr;
  logic [1:0] free_r;
  logic [1:0] free_nxt;

  function automatic logic last_byte(input logic [1:0] cnt, input logic [2:0] len);
    last_byte = ({1'b0, cnt} + 3'h1) >= len;
  endfunction

  function automatic logic [2:0] clamp_len(input logic [2:0] len);
    if (len == 3'h0) begin
      clamp_len = 3'h1;
    end else if (len > hpm_pkg::ROW_BYTES) begin
      clamp_len = hpm_pkg::ROW_BYTES;
    end else begin
      clamp_len = len;
    end
  endfunction

  hpm_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_level({scl_level, sda_level}),
    .q_level(pins_s)
  );

  hpm_qtr_tick u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(s_r.st != hpm_pkg::ST_IDLE),
    .tick(tick)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  // A released SCL may be held low by the device; wait until it is seen high
  assign adv = tick && (s_r.scl_low || scl_s);
  assign wr = s_r.seg != hpm_pkg::SG_RDATA;

  always_comb begin
    s_nxt = s_r;
    free_nxt = free_r;
    unique case (s_r.st)
      hpm_pkg::ST_IDLE: begin
        s_nxt.sel_n = 1'b1;
        if (cmd_valid) begin
          s_nxt.cmd = cmd;
          s_nxt.cmd.len = clamp_len(cmd.len);
          s_nxt.rsp = '0;
          s_nxt.qtr = 2'h0;
          s_nxt.bitn = 4'h0;
          s_nxt.byte_cnt = 2'h0;
          s_nxt.st = hpm_pkg::ST_START;
          s_nxt.sel_n = 1'b0;
          // Reading without a dummy write starts at the device's own counter
          if (cmd.rd && !cmd.set_addr) begin
            s_nxt.seg = hpm_pkg::SG_ADDRR;
          end else begin
            s_nxt.seg = hpm_pkg::SG_ADDRW;
          end
        end
      end
      hpm_pkg::ST_START: begin
        if (adv) begin
          s_nxt.qtr = s_r.qtr + 2'h1;
          unique case (s_r.qtr)
            2'h0: begin
              s_nxt.scl_low = 1'b1;
              s_nxt.sda_low = 1'b0;
            end
            2'h1: s_nxt.scl_low = 1'b0;
            2'h2: s_nxt.sda_low = 1'b1;
            2'h3: begin
              s_nxt.scl_low = 1'b1;
              s_nxt.st = hpm_pkg::ST_XFER;
              s_nxt.bitn = 4'h0;
              s_nxt.ack = 1'b1;
              // Address byte: device address above the direction bit
              s_nxt.shreg = {hpm_pkg::DEV_ADDR, (s_r.seg == hpm_pkg::SG_ADDRR) ?
                hpm_pkg::RW_READ : hpm_pkg::RW_WRITE};
            end
          endcase
        end
      end
      hpm_pkg::ST_XFER: begin
        if (adv) begin
          s_nxt.qtr = s_r.qtr + 2'h1;
          unique case (s_r.qtr)
            2'h0: begin
              // SCL is low here, so SDA may change
              if (s_r.bitn < 4'h8) begin
                s_nxt.sda_low = wr ? !s_r.shreg[7] : 1'b0;
              end else begin
                s_nxt.sda_low = wr ? 1'b0 : !last_byte(s_r.byte_cnt, s_r.cmd.len);
              end
            end
            2'h1: s_nxt.scl_low = 1'b0;
            2'h2: begin
              // SCL high: device data became valid after the last fall
              if (s_r.bitn < 4'h8) begin
                s_nxt.shreg = {s_r.shreg[6:0], sda_s};
              end else begin
                s_nxt.ack = sda_s;
              end
            end
            2'h3: begin
              s_nxt.scl_low = 1'b1;
              if (s_r.bitn < 4'h8) begin
                s_nxt.bitn = s_r.bitn + 4'h1;
              end else begin
                s_nxt.bitn = 4'h0;
                if (wr && s_r.ack) begin
                  // Busy or absent device: report and end; caller may poll
                  s_nxt.rsp.nack = 1'b1;
                  s_nxt.st = hpm_pkg::ST_STOP;
                end else begin
                  unique case (s_r.seg)
                    hpm_pkg::SG_ADDRW: begin
                      s_nxt.seg = hpm_pkg::SG_MEMA;
                      s_nxt.shreg = s_r.cmd.mem_addr;
                    end
                    hpm_pkg::SG_MEMA: begin
                      if (s_r.cmd.rd) begin
                        s_nxt.seg = hpm_pkg::SG_ADDRR;
                        s_nxt.st = hpm_pkg::ST_START;
                      end else begin
                        s_nxt.seg = hpm_pkg::SG_WDATA;
                        s_nxt.byte_cnt = 2'h0;
                        s_nxt.shreg = s_r.cmd.wdata[7:0];
                      end
                    end
                    hpm_pkg::SG_WDATA: begin
                      // All bytes of one row go in a single transfer
                      if (last_byte(s_r.byte_cnt, s_r.cmd.len)) begin
                        s_nxt.st = hpm_pkg::ST_STOP;
                      end else begin
                        s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
                        s_nxt.shreg = s_r.cmd.wdata[{s_r.byte_cnt + 2'h1, 3'h0} +: 8];
                      end
                    end
                    hpm_pkg::SG_ADDRR: begin
                      s_nxt.seg = hpm_pkg::SG_RDATA;
                      s_nxt.byte_cnt = 2'h0;
                    end
                    hpm_pkg::SG_RDATA: begin
                      s_nxt.rsp.rdata[{s_r.byte_cnt, 3'h0} +: 8] = s_r.shreg;
                      if (last_byte(s_r.byte_cnt, s_r.cmd.len)) begin
                        s_nxt.st = hpm_pkg::ST_STOP;
                      end else begin
                        s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      hpm_pkg::ST_STOP: begin
        if (adv) begin
          s_nxt.qtr = s_r.qtr + 2'h1;
          unique case (s_r.qtr)
            2'h0: s_nxt.sda_low = 1'b1;
            2'h1: s_nxt.scl_low = 1'b0;
            2'h2: s_nxt.sda_low = 1'b0;
            2'h3: begin
              s_nxt.st = hpm_pkg::ST_DONE;
              free_nxt = 2'h0;
            end
          endcase
        end
      end
      hpm_pkg::ST_DONE: begin
        // Keep the bus free for the minimum idle time before the next start
        if (tick) begin
          free_nxt = free_r + 2'h1;
        end
        if (free_r == hpm_pkg::BUS_FREE_QTRS) begin
          s_nxt.st = hpm_pkg::ST_IDLE;
          s_nxt.sel_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= hpm_pkg::STATE_RST;
      free_r <= 2'h0;
    end else begin
      s_r <= s_nxt;
      free_r <= free_nxt;
    end
  end

  assign cmd_ready = s_r.st == hpm_pkg::ST_IDLE;
  assign rsp_valid = (s_r.st == hpm_pkg::ST_DONE) && (free_r == hpm_pkg::BUS_FREE_QTRS);
  assign rsp = s_r.rsp;
  assign bus_select_n = s_r.sel_n;
  assign scl_value = 1'b0;
  assign scl_enable = s_r.scl_low;
  assign sda_value = 1'b0;
  assign sda_enable = s_r.sda_low;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_select_busy: assert property (s_r.st != hpm_pkg::ST_IDLE |-> !bus_select_n)
    else $error("bus select high during a transfer");
  a_addr_value: assert property ((s_r.st == hpm_pkg::ST_START && s_r.qtr == 2'h3 && adv)
    |=> s_r.shreg[7:1] == hpm_pkg::DEV_ADDR)
    else $error("address byte does not carry the device address");
  a_dir_bit: assert property ((s_r.st == hpm_pkg::ST_START && s_r.qtr == 2'h3 && adv)
    |=> s_r.shreg[0] == (s_r.seg == hpm_pkg::SG_ADDRR))
    else $error("direction bit wrong for the transfer");
  a_sda_hold: assert property ((s_r.st == hpm_pkg::ST_XFER && !s_r.scl_low
    && !$past(s_r.scl_low) && $past(s_r.st) == hpm_pkg::ST_XFER) |-> $stable(s_r.sda_low))
    else $error("SDA changed while SCL high");
  a_start_cond: assert property ((s_r.st == hpm_pkg::ST_START && s_r.qtr == 2'h2 && adv)
    |=> (s_r.sda_low && !s_r.scl_low) ##[1:300] s_r.scl_low)
    else $error("start condition malformed");
  a_stop_cond: assert property ((s_r.st == hpm_pkg::ST_STOP && s_r.qtr == 2'h2 && adv)
    |=> (!s_r.sda_low && !s_r.scl_low) ##[1:300] s_r.st == hpm_pkg::ST_DONE)
    else $error("stop condition malformed");
  a_read_nack: assert property ((s_r.st == hpm_pkg::ST_XFER && s_r.seg == hpm_pkg::SG_RDATA
    && s_r.bitn == 4'h8 && s_r.qtr == 2'h1)
    |-> s_r.sda_low == !last_byte(s_r.byte_cnt, s_r.cmd.len))
    else $error("read acknowledge wrong for byte position");
  a_ack_release: assert property ((s_r.st == hpm_pkg::ST_XFER && wr && s_r.bitn == 4'h8
    && s_r.qtr != 2'h0) |-> !s_r.sda_low)
    else $error("host drives SDA during device acknowledge");
  a_mem_second: assert property ($rose(s_r.seg == hpm_pkg::SG_MEMA)
    |-> s_r.shreg == s_r.cmd.mem_addr && $past(s_r.seg) == hpm_pkg::SG_ADDRW)
    else $error("memory address not sent after address byte");
  a_nack_stop: assert property ((s_r.st == hpm_pkg::ST_XFER && wr && s_r.bitn == 4'h8
    && s_r.qtr == 2'h3 && adv && s_r.ack)
    |=> s_r.st == hpm_pkg::ST_STOP && s_r.rsp.nack)
    else $error("device nack not ended with stop");
  a_row_len: assert property (s_r.st != hpm_pkg::ST_IDLE
    |-> s_r.cmd.len >= 3'h1 && s_r.cmd.len <= hpm_pkg::ROW_BYTES)
    else $error("transfer length outside one row");

endmodule

// *** sim/hpm_dev_model.sv ***
// Behavioural two-wire device with a small register map and password gating
`timescale 1ns/10ps
module hpm_dev_model #(
  parameter int BUSY_NS = 150000,
  parameter int STRETCH_NS = 0
) (
  input wire logic bus_select_n,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  localparam logic [6:0] OWN_ADDR = 7'b1010000;
  typedef enum logic [2:0] {M_OFF, M_ADDR, M_MEM, M_WR, M_RD} hpm_mode_t;
  hpm_mode_t mode = M_OFF;
  logic [7:0] mem [256];
  logic [7:0] shreg = 8'h00;
  logic [7:0] obyte = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [3:0] bitn = 4'h0;
  logic [31:0] password_entry = 32'h00000000;
  logic [31:0] mod_pw;
  logic [31:0] host_password_setting;
  logic mack = 1'b0;
  logic wrote = 1'b0;
  logic cond_a;
  logic cond_b;
  time busy_until = 0;

  // Conditioner outputs mirror lower-memory byte 01h
  assign cond_a = mem[8'h01][2];
  assign cond_b = mem[8'h01][1];

  assign mod_pw = {mem[8'hb8], mem[8'hb9], mem[8'hba], mem[8'hbb]};
  assign host_password_setting = {mem[8'h77], mem[8'h78], mem[8'h79], mem[8'h7a]};

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h80] = 8'h3c; // Scale presets, arbitrary
    mem[8'h81] = 8'h91;
    mem[8'h87] = 8'h80;
    mem[8'h88] = 8'hc3;
    mem[8'h7f] = 8'h01;
    mem[8'hb0] = 8'h00;
    mem[8'hb2] = 8'h03;
    mem[8'hb4] = 8'h00;
    {mem[8'hb8], mem[8'hb9], mem[8'hba], mem[8'hbb]} = 32'h0fffffff;
  end

  function automatic logic hidden(input logic [7:0] a);
    return a inside {[8'h77:8'h7e], [8'hb8:8'hbb]};
  endfunction

  task automatic store(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h7b && a <= 8'h7e) password_entry[8 * (8'h7e - a) +: 8] = d;
    else if (a >= 8'ha4 ? password_entry == mod_pw : (a inside {[8'h80:8'h83]} ? 1'b0 :
        (a >= 8'h77 && a <= 8'h7a ? password_entry == host_password_setting : 1'b1)))
      mem[a] = d;
  endtask

  task automatic take_byte();
    case (mode)
      M_ADDR: begin
        if (shreg[7:1] == OWN_ADDR && $time >= busy_until) begin
          sda_pull = 1'b1;
          mack = 1'b0;
          mode = shreg[0] ? M_RD : M_MEM;
        end else mode = M_OFF;
      end
      M_MEM: begin
        ptr = shreg;
        sda_pull = 1'b1;
        mode = M_WR;
      end
      default: begin
        store(ptr, shreg);
        ptr = {ptr[7:2], ptr[1:0] + 2'h1};
        wrote = 1'b1;
        sda_pull = 1'b1;
      end
    endcase
  endtask

  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitn = 4'h0;
      sda_pull = 1'b0;
      mode = bus_select_n ? M_OFF : M_ADDR;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      if (wrote && !mem[8'hb2][2]) busy_until = $time + BUSY_NS;
      wrote = 1'b0;
      mode = M_OFF;
      sda_pull = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (mode != M_OFF) begin
      if (bitn < 4'h8) shreg = {shreg[6:0], sda};
      else mack = sda;
      bitn = bitn + 4'h1;
    end
  end

  always @(negedge scl) begin
    if (mode != M_OFF) begin
      if (bitn == 4'h8) begin
        sda_pull = 1'b0;
        if (mode != M_RD) take_byte();
      end else if (bitn == 4'h9) begin
        bitn = 4'h0;
        sda_pull = 1'b0;
        if (mode == M_RD && mack) mode = M_OFF;
        else if (mode == M_RD) begin
          obyte = hidden(ptr) ? 8'h00 : mem[ptr];
          ptr = (ptr == 8'hff) ? 8'h80 : ptr + 8'h01;
        end
      end
      if (mode == M_RD && bitn < 4'h8) sda_pull = ~obyte[3'(4'h7 - bitn)];
      if (STRETCH_NS > 0 && bitn == 4'h0) begin
        scl_pull = 1'b1;
        #(STRETCH_NS);
        scl_pull = 1'b0;
      end
    end
  end
endmodule

// *** sim/hpm_master_tb.sv ***
// Self-checking bench: host controller against the behavioural device
`timescale 1ns/10ps
module hpm_master_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  hpm_pkg::hpm_cmd_t cmd = '0;
  logic cmd_ready;
  logic rsp_valid;
  hpm_pkg::hpm_rsp_t rsp;
  logic bus_select_n;
  logic scl_value;
  logic scl_enable;
  logic sda_value;
  logic sda_enable;
  logic scl_pull;
  logic sda_pull;
  wire logic scl_wire = ~((scl_enable & ~scl_value) | scl_pull);
  wire logic sda_wire = ~((sda_enable & ~sda_value) | sda_pull);
  int err_count = 0;
  int samples_checked = 0;
  int tries;

  always #(hpm_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  hpm_master uut (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
    .bus_select_n(bus_select_n), .scl_level(scl_wire), .scl_value(scl_value),
    .scl_enable(scl_enable), .sda_level(sda_wire), .sda_value(sda_value),
    .sda_enable(sda_enable));

  // Stretch outlasts the host's release quarter so the wait on a held SCL is exercised
  hpm_dev_model #(.BUSY_NS(150000), .STRETCH_NS(8000)) dev (.bus_select_n(bus_select_n),
    .scl(scl_wire), .sda(sda_wire), .scl_pull(scl_pull), .sda_pull(sda_pull));

  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One command through the user port, then wait for its result
  task automatic run_cmd(input logic rd, input logic set_addr, input logic [7:0] addr,
      input logic [2:0] len, input logic [31:0] wdata);
    int n;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd = '{rd: rd, set_addr: set_addr, mem_addr: addr, len: len, wdata: wdata};
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    check(32'(bus_select_n), 32'h0, "select during transfer");
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 60000) begin
      err_count++;
      $display("unexpected at %0t: no response", $time);
    end
    // Select and ready return in the cycle after the result pulse
    @(posedge clk_sys);
    #1;
    check(32'(rsp_valid), 32'h0, "result pulse one cycle");
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    check(32'(bus_select_n), 32'h1, "select idle");
    // Single byte write to an open location
    run_cmd(1'b0, 1'b0, 8'h87, 3'h1, 32'h0000005a);
    check(32'(rsp.nack), 32'h0, "write acknowledged");
    check(32'(dev.mem[8'h87]), 32'h5a, "stored byte");
    check(32'(bus_select_n), 32'h1, "select released");
    check(32'({dev.cond_a, dev.cond_b}), 32'h0, "conditioner outputs");
    // Device is still busy with its row write and refuses the address
    run_cmd(1'b1, 1'b1, 8'h87, 3'h2, 32'h0);
    check(32'(rsp.nack), 32'h1, "address refused while busy");
    check(rsp.rdata, 32'h0, "no data on refusal");
    // Acknowledge polling until the device answers again
    tries = 0;
    do begin
      run_cmd(1'b1, 1'b1, 8'h87, 3'h2, 32'h0);
      tries++;
    end while (rsp.nack === 1'b1 && tries < 3);
    check(32'(rsp.nack), 32'h0, "read acknowledged");
    check(rsp.rdata, 32'h0000c35a, "two byte readback");
    check(32'(sda_pull), 32'h0, "device released data line");
    check(32'(cmd_ready), 32'h1, "ready after result");
    end_sim;
  end

  initial begin
    repeat (99000) @(posedge clk_sys);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule
